// ==== logic/run_input_function_selector.sv ====
/*
  Run and input function selector: Wishbone register file, run/stop
  sequencing, fault latch, ramp and speed selection, block and search.
  Assumes terminals are synchronous to CLK and MOTOR_RUNNING comes from
  the speed core, high while the output frequency is not zero.
*/
`timescale 1ns/100ps
module run_input_function_selector
  import run_select_pkg::*;
#(
  parameter int FLASH_CYCLES = FLASH_CYCLES_DEF,
  parameter bit LARGE_RATING = 1'b0
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Wishbone slave
  input wire logic [11:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic WB_WE_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic IRQ,
  // Terminals and speed core feedback
  input wire logic [NUM_INPUTS-1:0] TERM_IN,
  input wire logic MOTOR_RUNNING,
  // Drive commands
  output logic RUN_FWD,
  output logic RUN_REV,
  output logic DRIVE_ENABLE,
  output logic RAMP_STOP,
  output logic ACCEL_SECOND,
  output logic DECEL_SECOND,
  output logic [3:0] SPEED_STEP,
  output logic INCH_SELECT,
  output logic SEARCH_MAX,
  output logic SEARCH_PRESET,
  // Indications
  output logic FAULT,
  output logic [2:0] FAULT_TERM,
  output logic BLOCK_FLASH,
  output logic OVERHEAT_WARN
);
  localparam int FW = $clog2(FLASH_CYCLES + 1);

  input_func_if fo();
  logic [CODE_W-1:0] stop_mode_reg, stop_mode_next;
  logic [CODE_W-1:0] rev_lock_reg, rev_lock_next;
  logic [CODE_W-1:0] func_reg [NUM_INPUTS];
  logic [CODE_W-1:0] func_next [NUM_INPUTS];
  logic [STATUS_W-1:0] status_reg, status_next, mask_reg, mask_next, events;
  logic [31:0] rd_data;
  logic [15:0] cur_val, wr_val;
  logic [9:0] idx;
  logic req, wr, rd, refused, locked;
  drive_state_t state_reg, state_next;
  logic dir_reg, dir_next, three_run_reg, three_run_next;
  logic fault_next;
  logic [2:0] term_next;
  logic fwd_cmd, rev_cmd, run_any, halt;
  logic [FW-1:0] flash_cnt_reg, flash_cnt_next;
  logic flash_reg, flash_next;
  logic block_seen_reg;

  terminal_decoder #(.N(NUM_INPUTS)) u_dec (
    .level(TERM_IN),
    .code(func_reg),
    .fo(fo)
  );

  // Accepted code per terminal; input 3 alone takes three-wire
  function automatic logic code_ok(input int i, input logic [15:0] c);
    code_ok = (c >= FN_FWD && c <= FN_LAST)
      || (c == FN_THREE_WIRE && i == THREE_WIRE_INPUT)
      || (c == FN_OVERHEAT && LARGE_RATING)
      || (i == UPDOWN_INPUT && (c == FN_UPDOWN || c == FN_UPDOWN_ALT));
  endfunction

  // Bus decode; a request is served in the cycle before ack rises
  assign idx = WB_ADR_I[11:2];
  assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wr = req && WB_WE_I;
  assign rd = req && !WB_WE_I;
  assign locked = MOTOR_RUNNING || (state_reg != DRV_IDLE);

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_data = 32'h0000_0000;
    if (idx == IDX_STOP_MODE) rd_data[15:0] = stop_mode_reg;
    if (idx == IDX_REV_LOCK) rd_data[15:0] = rev_lock_reg;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      if (idx == IDX_IN_ONE + 10'(i)) rd_data[15:0] = func_reg[i];
    end
    if (idx == IDX_STATUS) rd_data[STATUS_W-1:0] = status_reg;
    if (idx == IDX_MASK) rd_data[STATUS_W-1:0] = mask_reg;
    if (idx == IDX_STATE) begin
      rd_data[1:0] = state_reg;
      rd_data[SR_DIR] = dir_reg;
      rd_data[SR_FAULT] = FAULT;
      rd_data[SR_TERM_LSB +: 3] = FAULT_TERM;
      rd_data[SR_LOCKED] = locked;
    end
  end

  // Byte lanes merge into the current value of the addressed setting
  assign cur_val = rd_data[15:0];
  assign wr_val = {WB_SEL_I[1] ? WB_DAT_I[15:8] : cur_val[15:8],
    WB_SEL_I[0] ? WB_DAT_I[7:0] : cur_val[7:0]};

  // Settings other than the mask: writes refused while running or with an illegal value
  always_comb begin
    stop_mode_next = stop_mode_reg;
    rev_lock_next = rev_lock_reg;
    mask_next = mask_reg;
    refused = 1'b0;
    for (int i = 0; i < NUM_INPUTS; i++) func_next[i] = func_reg[i];
    if (wr && idx == IDX_MASK && WB_SEL_I[0]) mask_next = wr_val[STATUS_W-1:0];
    if (wr && (idx == IDX_STOP_MODE || idx == IDX_REV_LOCK)) begin
      if (locked || wr_val > 16'h0001) refused = 1'b1;
      else if (idx == IDX_STOP_MODE) stop_mode_next = wr_val;
      else rev_lock_next = wr_val;
    end
    for (int i = 0; i < NUM_INPUTS; i++) begin
      if (wr && idx == IDX_IN_ONE + 10'(i)) begin
        if (locked || !code_ok(i, wr_val)) refused = 1'b1;
        else func_next[i] = wr_val;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      stop_mode_reg <= RST_STOP_MODE;
      rev_lock_reg <= RST_REV_LOCK;
      mask_reg <= '0;
      for (int i = 0; i < NUM_INPUTS; i++) func_reg[i] <= RST_IN_FUNC[i];
    end else begin
      stop_mode_reg <= stop_mode_next;
      rev_lock_reg <= rev_lock_next;
      mask_reg <= mask_next;
      for (int i = 0; i < NUM_INPUTS; i++) func_reg[i] <= func_next[i];
    end
  end

  // Sticky events; an event in the clearing read still lands
  always_comb begin
    events = '0;
    events[SB_FAULT] = fault_next && !FAULT;
    events[SB_REFUSED] = refused;
    events[SB_BLOCK] = fo.block && !halt_block_seen();
    events[SB_SEARCH] = (fo.search_max && !SEARCH_MAX)
      || (fo.search_preset && !SEARCH_PRESET);
    status_next = status_reg;
    if (rd && idx == IDX_STATUS) status_next = '0;
    status_next = status_next | events;
  end

  function automatic logic halt_block_seen();
    halt_block_seen = block_seen_reg; // Block already present last cycle
  endfunction

  // Bus answer one cycle after the request; ack drops the cycle after
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      status_reg <= '0;
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
      IRQ <= 1'b0;
    end else begin
      status_reg <= status_next;
      WB_ACK_O <= req;
      WB_DAT_O <= rd ? rd_data : 32'h0000_0000;
      IRQ <= |(status_next & mask_next);
    end
  end

  // Run commands; a held reverse is dropped under lockout
  always_comb begin
    three_run_next = fo.three_stop_n && (fo.three_run || three_run_reg);
    if (fo.three_wire) begin
      run_any = three_run_next;
      fwd_cmd = three_run_next && !fo.three_dir;
      rev_cmd = three_run_next && fo.three_dir && !rev_lock_reg[0];
    end else begin
      run_any = fo.fwd || fo.rev;
      fwd_cmd = fo.fwd && !fo.rev;
      rev_cmd = fo.rev && !fo.fwd && !rev_lock_reg[0];
    end
    halt = FAULT || fo.block;
  end

  // Fault latch: a reset clears it for one cycle even while a fault stands; reset refused under a run command
  always_comb begin
    fault_next = FAULT;
    term_next = FAULT_TERM;
    if (fo.reset_req && !run_any) fault_next = 1'b0;
    if (fo.fault_req && !FAULT) begin
      fault_next = 1'b1;
      term_next = fo.fault_term;
    end
  end

  // Drive sequence; coasting holds until the motor has stopped
  always_comb begin
    state_next = state_reg;
    dir_next = dir_reg;
    unique case (state_reg)
      DRV_IDLE: begin
        if (!halt && (fwd_cmd || rev_cmd)) begin
          state_next = DRV_RUN;
          dir_next = rev_cmd;
        end
      end
      DRV_RUN: begin
        if (halt) state_next = DRV_COAST;
        else if (!(dir_reg ? rev_cmd : fwd_cmd))
          state_next = stop_mode_reg[0] ? DRV_COAST : DRV_RAMP;
      end
      DRV_RAMP: begin
        if (halt) state_next = DRV_COAST;
        else if (!MOTOR_RUNNING) state_next = DRV_IDLE;
      end
      DRV_COAST: begin
        if (!halt && !MOTOR_RUNNING) state_next = DRV_IDLE;
      end
    endcase
  end

  // Flash divider for the block indication
  always_comb begin
    flash_cnt_next = flash_cnt_reg + FW'(1);
    flash_next = flash_reg;
    if (flash_cnt_reg == FW'(FLASH_CYCLES - 1)) begin
      flash_cnt_next = '0;
      flash_next = !flash_reg;
    end
  end

  // All command and indication outputs are registered
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_reg <= DRV_IDLE;
      dir_reg <= 1'b0;
      three_run_reg <= 1'b0;
      flash_cnt_reg <= '0;
      flash_reg <= 1'b0;
      block_seen_reg <= 1'b0;
      FAULT <= 1'b0;
      FAULT_TERM <= 3'h0;
      RUN_FWD <= 1'b0;
      RUN_REV <= 1'b0;
      DRIVE_ENABLE <= 1'b1;
      RAMP_STOP <= 1'b0;
      ACCEL_SECOND <= 1'b0;
      DECEL_SECOND <= 1'b0;
      SPEED_STEP <= 4'h0;
      INCH_SELECT <= 1'b0;
      SEARCH_MAX <= 1'b0;
      SEARCH_PRESET <= 1'b0;
      BLOCK_FLASH <= 1'b0;
      OVERHEAT_WARN <= 1'b0;
    end else begin
      state_reg <= state_next;
      dir_reg <= dir_next;
      three_run_reg <= three_run_next;
      flash_cnt_reg <= flash_cnt_next;
      flash_reg <= flash_next;
      block_seen_reg <= fo.block;
      FAULT <= fault_next;
      FAULT_TERM <= term_next;
      RUN_FWD <= (state_next == DRV_RUN) && !dir_next;
      RUN_REV <= (state_next == DRV_RUN) && dir_next;
      // Block removes output even from idle, so a start cannot slip through
      DRIVE_ENABLE <= (state_next != DRV_COAST) && !fo.block;
      RAMP_STOP <= (state_next == DRV_RAMP);
      ACCEL_SECOND <= fo.ramp2;
      DECEL_SECOND <= fo.ramp2; // First decel unless code 11 selects
      SPEED_STEP <= fo.inch ? 4'h0 : fo.step;
      INCH_SELECT <= fo.inch;
      SEARCH_MAX <= fo.search_max;
      SEARCH_PRESET <= fo.search_preset;
      BLOCK_FLASH <= fo.block && flash_next;
      OVERHEAT_WARN <= fo.overheat;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_three_start;
    fo.three_wire && fo.three_run && fo.three_stop_n && !fo.three_dir
      && state_reg == DRV_IDLE && !halt;
  endsequence

  sequence s_run_no_cmd;
    state_reg == DRV_RUN && !halt && !(dir_reg ? rev_cmd : fwd_cmd);
  endsequence

  a_rev_lockout: assert property (rev_lock_reg[0] |-> !RUN_REV)
    else $error("reverse run under lockout");
  a_coast_stop: assert property (s_run_no_cmd ##0 stop_mode_reg[0]
    |=> !DRIVE_ENABLE && !RUN_FWD && !RUN_REV)
    else $error("coast stop did not remove output");
  a_ramp_stop: assert property (s_run_no_cmd ##0 !stop_mode_reg[0]
    |=> RAMP_STOP && DRIVE_ENABLE)
    else $error("ramp stop not entered");
  a_decel_select: assert property (1'b1 |=> DECEL_SECOND == $past(fo.ramp2))
    else $error("decel time select mismatch");
  a_three_wire_run: assert property (s_three_start |=> RUN_FWD)
    else $error("three-wire run did not start forward");
  a_fault_latch: assert property (fo.fault_req && !FAULT
    |=> FAULT && FAULT_TERM == $past(fo.fault_term))
    else $error("fault or terminal not latched");
  a_reset_refused: assert property (FAULT && run_any |=> FAULT)
    else $error("fault cleared under run command");
  a_inch_first: assert property (fo.inch |=> INCH_SELECT && SPEED_STEP == 4'h0)
    else $error("inching did not override step");
  a_block_coast: assert property (fo.block ##1 fo.block |-> !DRIVE_ENABLE)
    else $error("block did not remove output");
  a_cfg_locked: assert property (locked
    |=> $stable(stop_mode_reg) && $stable(rev_lock_reg) && $stable(func_reg[0]))
    else $error("setting changed while running");
endmodule

// ==== common/run_select_pkg.sv ====
/*
  Constants for the run and input function selector: register indices,
  reset values, function codes, status layout and timing.
  Assumes a 10 MHz system clock and a 32-bit classic Wishbone slave.
*/
package run_select_pkg;
  localparam int NUM_INPUTS = 7;
  localparam int CODE_W = 16;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_STOP_MODE = 10'h105;
  localparam logic [9:0] IDX_REV_LOCK = 10'h106;
  localparam logic [9:0] IDX_IN_ONE = 10'h132;
  localparam logic [9:0] IDX_IN_TWO = 10'h133;
  localparam logic [9:0] IDX_IN_THREE = 10'h134;
  localparam logic [9:0] IDX_IN_FOUR = 10'h135;
  localparam logic [9:0] IDX_IN_FIVE = 10'h136;
  localparam logic [9:0] IDX_IN_SIX = 10'h137;
  localparam logic [9:0] IDX_IN_SEVEN = 10'h138;
  localparam logic [9:0] IDX_STATUS = 10'h140;
  localparam logic [9:0] IDX_MASK = 10'h141;
  localparam logic [9:0] IDX_STATE = 10'h142;
  // Reset values
  localparam logic [15:0] RST_STOP_MODE = 16'h0000;
  localparam logic [15:0] RST_REV_LOCK = 16'h0000;
  localparam logic [15:0] RST_IN_FUNC [NUM_INPUTS] =
    '{16'h0001, 16'h0002, 16'h0003, 16'h0005, 16'h0006, 16'h0007, 16'h000A};
  // Function codes
  localparam logic [15:0] FN_THREE_WIRE = 16'h0000;
  localparam logic [15:0] FN_FWD = 16'h0001;
  localparam logic [15:0] FN_REV = 16'h0002;
  localparam logic [15:0] FN_FAULT_NO = 16'h0003;
  localparam logic [15:0] FN_FAULT_NC = 16'h0004;
  localparam logic [15:0] FN_RESET = 16'h0005;
  localparam logic [15:0] FN_STEP1 = 16'h0006;
  localparam logic [15:0] FN_INCH = 16'h000A;
  localparam logic [15:0] FN_RAMP2 = 16'h000B;
  localparam logic [15:0] FN_BLOCK_NO = 16'h000C;
  localparam logic [15:0] FN_BLOCK_NC = 16'h000D;
  localparam logic [15:0] FN_SEARCH_MAX = 16'h000E;
  localparam logic [15:0] FN_SEARCH_SET = 16'h000F;
  localparam logic [15:0] FN_LAST = 16'h0019;
  localparam logic [15:0] FN_OVERHEAT = 16'h001A;
  localparam logic [15:0] FN_UPDOWN = 16'h0022;
  localparam logic [15:0] FN_UPDOWN_ALT = 16'h0023;
  localparam int THREE_WIRE_INPUT = 2;
  localparam int UPDOWN_INPUT = 6;
  // Status and mask bit positions
  localparam int STATUS_W = 4;
  localparam int SB_FAULT = 0;
  localparam int SB_REFUSED = 1;
  localparam int SB_BLOCK = 2;
  localparam int SB_SEARCH = 3;
  // State register fields
  localparam int SR_DIR = 2;
  localparam int SR_FAULT = 3;
  localparam int SR_TERM_LSB = 4;
  localparam int SR_LOCKED = 7;
  // Block indication flash half period
  localparam int CLK_HZ = 10_000_000;
  localparam int FLASH_HALF_MS = 500;
  localparam int FLASH_CYCLES_DEF = FLASH_HALF_MS * (CLK_HZ / 1000);
  typedef enum logic [1:0] {DRV_IDLE, DRV_RUN, DRV_RAMP, DRV_COAST} drive_state_t;
endpackage

// ==== common/input_func_if.sv ====
/*
  Decoded terminal functions passed from the terminal decoder to the
  selector core. Purely combinational, one clock domain.
*/
`timescale 1ns/100ps
interface input_func_if;
  logic fwd;
  logic rev;
  logic three_wire;
  logic three_run;
  logic three_stop_n;
  logic three_dir;
  logic fault_req;
  logic [2:0] fault_term;
  logic reset_req;
  logic [3:0] step;
  logic inch;
  logic ramp2;
  logic block;
  logic search_max;
  logic search_preset;
  logic overheat;
  modport src(output fwd, rev, three_wire, three_run, three_stop_n, three_dir,
    fault_req, fault_term, reset_req, step, inch, ramp2, block, search_max,
    search_preset, overheat);
  modport dst(input fwd, rev, three_wire, three_run, three_stop_n, three_dir,
    fault_req, fault_term, reset_req, step, inch, ramp2, block, search_max,
    search_preset, overheat);
endinterface

// ==== logic/terminal_decoder.sv ====
/*
  Maps the seven terminal levels through their function codes onto the
  decoded function lines. Combinational; terminals are already synchronous.
*/
`timescale 1ns/100ps
module terminal_decoder
  import run_select_pkg::*;
#(
  parameter int N = NUM_INPUTS
) (
  // Terminal levels and their function codes
  input wire logic [N-1:0] level,
  input wire logic [CODE_W-1:0] code [N],
  // Decoded functions
  input_func_if.src fo
);
  logic tw;
  logic hit;

  // Each terminal contributes to the function its code names
  always_comb begin
    tw = (code[THREE_WIRE_INPUT] == FN_THREE_WIRE);
    hit = 1'b0;
    fo.fwd = 1'b0;
    fo.rev = 1'b0;
    fo.three_wire = tw;
    fo.three_run = level[0];
    fo.three_stop_n = level[1];
    fo.three_dir = level[THREE_WIRE_INPUT];
    fo.fault_req = 1'b0;
    fo.fault_term = 3'h0;
    fo.reset_req = 1'b0;
    fo.step = 4'h0; // Unassigned selector bits read as off
    fo.inch = 1'b0;
    fo.ramp2 = 1'b0;
    fo.block = 1'b0;
    fo.search_max = 1'b0;
    fo.search_preset = 1'b0;
    fo.overheat = 1'b0;
    for (int i = 0; i < N; i++) begin
      // Three-wire mode overrides the first three settings
      if (!(tw && i <= THREE_WIRE_INPUT)) begin
        unique case (code[i])
          FN_FWD: fo.fwd = fo.fwd | level[i];
          FN_REV: fo.rev = fo.rev | level[i];
          FN_FAULT_NO, FN_FAULT_NC: begin
            hit = (code[i] == FN_FAULT_NO) ? level[i] : !level[i];
            if (hit && !fo.fault_req) begin
              fo.fault_req = 1'b1;
              fo.fault_term = 3'(i + 1); // Lowest faulting terminal is reported
            end
          end
          FN_RESET: fo.reset_req = fo.reset_req | level[i];
          FN_STEP1, FN_STEP1 + 16'h0001, FN_STEP1 + 16'h0002, FN_STEP1 + 16'h0003:
            fo.step[2'(code[i] - FN_STEP1)] = fo.step[2'(code[i] - FN_STEP1)] | level[i];
          FN_INCH: fo.inch = fo.inch | level[i];
          FN_RAMP2: fo.ramp2 = fo.ramp2 | level[i];
          FN_BLOCK_NO: fo.block = fo.block | level[i];
          FN_BLOCK_NC: fo.block = fo.block | !level[i];
          FN_SEARCH_MAX: fo.search_max = fo.search_max | level[i];
          FN_SEARCH_SET: fo.search_preset = fo.search_preset | level[i];
          FN_OVERHEAT: fo.overheat = fo.overheat | level[i];
          default: ; // Codes handled elsewhere in the drive
        endcase
      end
    end
  end
endmodule

// ==== tb/terminal_model.sv ====
/*
  Far side model: seven switches on the terminals and the speed core's
  running flag. Assumes the bench names the wanted switch pattern and the
  drive's run commands arrive as one level.
*/
`timescale 1ns/100ps
module terminal_model #(
  parameter int SPIN_DOWN = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Wanted switches and run command from the drive
  input wire logic [6:0] want,
  input wire logic run_cmd,
  // Terminal levels and speed feedback
  output logic [6:0] term,
  output logic motor_running
);
  int spin;
  // Contacts settle one clock after the request; the motor turns on for
  // SPIN_DOWN cycles after the command goes, so a stop takes real time
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      term <= 7'h00;
      spin <= 0;
    end else begin
      term <= want;
      if (run_cmd) begin
        spin <= SPIN_DOWN;
      end else if (spin != 0) begin
        spin <= spin - 1;
      end
    end
  end
  // Output frequency is nonzero while the motor turns
  assign motor_running = (spin != 0);
endmodule

// ==== tb/tb.sv ====
/*
  Self-checking bench for the run and input function selector.
  Assumes terminal_model on the terminals and one 10 MHz clock.
*/
`timescale 1ns/100ps
module tb;
  import run_select_pkg::*;
  typedef struct packed {
    logic [9:0] idx;
    logic [15:0] code;
    logic [6:0] want;
    logic [15:0] rd;
    logic [15:0] obs;
  } row_t;
  // Setting written, switches, read-back and drive outputs expected
  localparam row_t ROWS [16] = '{
    '{IDX_IN_FOUR, 16'h0006, 7'h08, 16'h0006, 16'h0021},
    '{IDX_IN_FOUR, 16'h0009, 7'h08, 16'h0009, 16'h0028},
    '{IDX_IN_FOUR, 16'h000A, 7'h08, 16'h000A, 16'h0120},
    '{IDX_IN_FOUR, 16'h000B, 7'h08, 16'h000B, 16'h0620},
    '{IDX_IN_FOUR, 16'h000C, 7'h08, 16'h000C, 16'h0000},
    '{IDX_IN_FOUR, 16'h000D, 7'h00, 16'h000D, 16'h0000},
    '{IDX_IN_FOUR, 16'h000E, 7'h08, 16'h000E, 16'h00A0},
    '{IDX_IN_FOUR, 16'h000F, 7'h08, 16'h000F, 16'h0060},
    '{IDX_IN_FOUR, 16'h001A, 7'h08, 16'h000F, 16'h0060},
    '{IDX_IN_FOUR, 16'h0005, 7'h50, 16'h0005, 16'h0120},
    '{IDX_IN_ONE, 16'h0000, 7'h00, 16'h0001, 16'h0020},
    '{IDX_IN_TWO, 16'h0023, 7'h00, 16'h0002, 16'h0020},
    '{IDX_IN_SEVEN, 16'h0022, 7'h00, 16'h0022, 16'h0020},
    '{10'h200, 16'h05A5, 7'h00, 16'h0000, 16'h0020},
    '{IDX_IN_THREE, 16'h0000, 7'h03, 16'h0000, 16'h0820},
    '{IDX_IN_THREE, 16'h0003, 7'h01, 16'h0000, 16'h0020}
  };
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [11:0] WB_ADR_I = 12'h000;
  logic [31:0] WB_DAT_I = 32'h00000000;
  logic [3:0] WB_SEL_I = 4'hF;
  logic WB_WE_I = 1'b0;
  logic WB_CYC_I = 1'b0;
  logic WB_STB_I = 1'b0;
  logic [31:0] WB_DAT_O;
  logic WB_ACK_O, IRQ, MOTOR_RUNNING, RUN_FWD, RUN_REV, DRIVE_ENABLE, RAMP_STOP;
  logic ACCEL_SECOND, DECEL_SECOND, INCH_SELECT, SEARCH_MAX, SEARCH_PRESET;
  logic FAULT, BLOCK_FLASH, OVERHEAT_WARN;
  logic [2:0] FAULT_TERM;
  logic [3:0] SPEED_STEP;
  logic [6:0] TERM_IN;
  logic [6:0] want = 7'h00;
  logic [3:0] lanes = 4'hF;
  logic [15:0] rd;
  logic fb;
  int k;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;

  // Short flash period keeps the block indication test brief
  run_input_function_selector #(.FLASH_CYCLES(4), .LARGE_RATING(1'b0)) i_run_input_function_selector (
    .CLK(CLK), .RST(RST), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_SEL_I(WB_SEL_I),
    .WB_WE_I(WB_WE_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .IRQ(IRQ), .TERM_IN(TERM_IN), .MOTOR_RUNNING(MOTOR_RUNNING),
    .RUN_FWD(RUN_FWD), .RUN_REV(RUN_REV), .DRIVE_ENABLE(DRIVE_ENABLE), .RAMP_STOP(RAMP_STOP),
    .ACCEL_SECOND(ACCEL_SECOND), .DECEL_SECOND(DECEL_SECOND), .SPEED_STEP(SPEED_STEP),
    .INCH_SELECT(INCH_SELECT), .SEARCH_MAX(SEARCH_MAX), .SEARCH_PRESET(SEARCH_PRESET),
    .FAULT(FAULT), .FAULT_TERM(FAULT_TERM), .BLOCK_FLASH(BLOCK_FLASH),
    .OVERHEAT_WARN(OVERHEAT_WARN));
  terminal_model #(.SPIN_DOWN(10)) i_terminal_model (.clk(CLK), .rst(RST), .want(want),
    .run_cmd(RUN_FWD | RUN_REV), .term(TERM_IN), .motor_running(MOTOR_RUNNING));

  // Clock and hang guard
  always #50 CLK = ~CLK;
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One classic cycle; ack and read data are taken at the rising edge
  task automatic wb(input logic [9:0] idx, input logic we, input logic [15:0] wd);
    int n;
    n = 0;
    @(posedge CLK);
    WB_ADR_I <= {idx, 2'b00};
    WB_DAT_I <= {16'hFFFF, wd};
    WB_SEL_I <= lanes;
    WB_WE_I <= we;
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (WB_ACK_O !== 1'b1 && n < 40);
    rd = WB_DAT_O[15:0];
    if (n >= 40) mismatches++;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    WB_WE_I <= 1'b0;
    @(negedge CLK);
  endtask

  task automatic rd_check(input string name, input logic [9:0] idx, input logic [15:0] exp);
    wb(idx, 1'b0, 16'h0000);
    check(name, exp, rd);
  endtask

  // Switches change after an edge; outputs are read once settled
  task automatic drive(input logic [6:0] w);
    @(posedge CLK);
    want <= w;
    repeat (3) @(posedge CLK);
    @(negedge CLK);
  endtask

  task automatic idle_wait();
    repeat (60) if (RAMP_STOP === 1'b1 || DRIVE_ENABLE !== 1'b1 || MOTOR_RUNNING === 1'b1)
      @(negedge CLK);
    repeat (2) @(negedge CLK);
    check("stopped", 16'h0001, {14'h0000, RAMP_STOP, DRIVE_ENABLE});
  endtask

  function automatic logic [15:0] obs();
    return {2'h0, OVERHEAT_WARN, RUN_REV, RUN_FWD, ACCEL_SECOND, DECEL_SECOND, INCH_SELECT, SEARCH_MAX,
      SEARCH_PRESET, DRIVE_ENABLE, FAULT, SPEED_STEP};
  endfunction

  initial begin
    repeat (20) @(posedge CLK);
    RST <= 1'b0;
    foreach (ROWS[i]) begin
      wb(ROWS[i].idx, 1'b1, ROWS[i].code);
      rd_check("setting", ROWS[i].idx, ROWS[i].rd);
      drive(ROWS[i].want);
      check("outputs", ROWS[i].obs, obs());
    end
    idle_wait();
    // Only the low byte lane is enabled; the upper byte must stay
    lanes = 4'h1;
    wb(IDX_IN_SIX, 1'b1, 16'hFF08);
    lanes = 4'hF;
    rd_check("lane", IDX_IN_SIX, 16'h0008);
    // Block indication toggles every four cycles
    wb(IDX_IN_FIVE, 1'b1, 16'h000C);
    drive(7'h10);
    k = 0;
    fb = BLOCK_FLASH;
    repeat (12) begin
      @(negedge CLK);
      if (BLOCK_FLASH !== fb) k++;
      fb = BLOCK_FLASH;
    end
    check("flash", 16'h0003, k[15:0]);
    drive(7'h00);
    // Reset while idle restores every setting
    @(posedge CLK);
    RST <= 1'b1;
    repeat (3) @(posedge CLK);
    @(negedge CLK);
    check("reset outputs", 16'h0020, obs());
    @(posedge CLK);
    RST <= 1'b0;
    foreach (RST_IN_FUNC[i]) rd_check("func reset", IDX_IN_ONE + 10'(i), RST_IN_FUNC[i]);
    rd_check("stop reset", IDX_STOP_MODE, RST_STOP_MODE);
    rd_check("lock reset", IDX_REV_LOCK, RST_REV_LOCK);
    rd_check("unmapped", IDX_STATE + 10'h010, 16'h0000);
    // Fault latch, its terminal, reset refusal and the interrupt path
    wb(IDX_MASK, 1'b1, 16'h0003);
    drive(7'h04);
    check("fault", 16'h0007, {12'h000, FAULT_TERM, FAULT});
    check("irq", 16'h0001, {15'h0000, IRQ});
    rd_check("status", IDX_STATUS, 16'h0001);
    drive(7'h00);
    check("irq clear", 16'h0000, {15'h0000, IRQ});
    check("fault held", 16'h0007, {12'h000, FAULT_TERM, FAULT});
    rd_check("state", IDX_STATE, 16'h0038);
    drive(7'h09);
    check("reset in run", 16'h0001, {15'h0000, FAULT});
    drive(7'h08);
    check("reset", 16'h0000, {15'h0000, FAULT});
    drive(7'h00);
    // Ramped stop, and a setting write refused while running
    drive(7'h01);
    check("run fwd", 16'h0001, {15'h0000, RUN_FWD});
    wb(IDX_STOP_MODE, 1'b1, 16'h0001);
    rd_check("locked", IDX_STOP_MODE, 16'h0000);
    check("refused irq", 16'h0001, {15'h0000, IRQ});
    rd_check("refused", IDX_STATUS, 16'h0002);
    drive(7'h00);
    check("ramp stop", 16'h0003, {14'h0000, RAMP_STOP, DRIVE_ENABLE});
    idle_wait();
    // Coasting stop
    wb(IDX_STOP_MODE, 1'b1, 16'h0001);
    drive(7'h01);
    drive(7'h00);
    check("coast stop", 16'h0000, {14'h0000, RAMP_STOP, DRIVE_ENABLE});
    idle_wait();
    wb(IDX_STOP_MODE, 1'b1, 16'h0000);
    // Reverse honoured, then ignored under lockout
    drive(7'h02);
    check("run rev", 16'h0001, {15'h0000, RUN_REV});
    drive(7'h00);
    idle_wait();
    wb(IDX_REV_LOCK, 1'b1, 16'h0001);
    drive(7'h02);
    check("rev locked", 16'h0000, {14'h0000, RUN_REV, RUN_FWD});
    drive(7'h00);
    conclude();
  end
endmodule
